/* File: inc/dms_consts.vh */
// Constants for the converter mode and switch decoder
`ifndef DMS_CONSTS_VH
`define DMS_CONSTS_VH

// Register byte offsets (printed offsets 0x1 to 0x3 and 0x7 are not word aligned,
// so they are kept as indices and the byte address is four times each)
`define DMS_IDX_CTRL 3'h0
`define DMS_IDX_RSVD1 3'h1
`define DMS_IDX_LEVEL 3'h2
`define DMS_IDX_RSVD7 3'h7
`define DMS_IDX_STOP 3'h3
`define DMS_ADDR_W 12
`define DMS_ADDR_CTRL 12'h000
`define DMS_ADDR_LEVEL 12'h008
`define DMS_ADDR_STOP 12'h00C
`define DMS_ADDR_RSVD1 12'h004
`define DMS_ADDR_RSVD7 12'h01C

// Field positions in the control register
`define DMS_FLD_RANGE 7
`define DMS_FLD_DRIVE 6
`define DMS_FLD_MODE_HI 2
`define DMS_FLD_MODE_LO 0

// Mode encodings
`define DMS_MODE_OFF 3'h0
`define DMS_MODE_AMP 3'h1
`define DMS_MODE_INT 3'h2
`define DMS_MODE_UNBUF 3'h4
`define DMS_MODE_UNBUF_AMP 3'h5
`define DMS_MODE_BUF 3'h7

// Reset values
`define DMS_RST_MODE 3'h0
`define DMS_RST_RANGE 1'b1
`define DMS_RST_DRIVE 1'b0
`define DMS_RST_LEVEL 8'h00

`endif

/* File: rtl/dms_decode.v */
// Combinational mode decoder for ladder, amplifier and switch controls
`timescale 1ns/10ps
`default_nettype none
`include "dms_consts.vh"

module dms_decode (
    input wire [2:0] i_mode,        // Stored mode field
    input wire i_stop,              // System stop request
    output reg o_ladder_en,         // Resistor network enable
    output reg o_amp_en,            // Amplifier enable
    output reg o_sw_one,            // Switch one closed
    output reg o_sw_two,            // Switch two closed
    output reg o_sw_three,          // Switch three closed
    output reg o_int_node,          // Ladder output onto internal node
    output reg o_valid              // Encoding is a supported mode
);

    // Table lookup, then the stop override on amplifier and switches 1, 2
    always @* begin
        o_ladder_en = 1'b0;
        o_amp_en = 1'b0;
        o_sw_one = 1'b0;
        o_sw_two = 1'b0;
        o_sw_three = 1'b0;
        o_valid = 1'b1;
        case (i_mode)
            `DMS_MODE_OFF: begin
                o_valid = 1'b1;
            end
            `DMS_MODE_AMP: begin
                o_amp_en = 1'b1;
                o_sw_one = 1'b1;
            end
            `DMS_MODE_INT: begin
                o_ladder_en = 1'b1;
            end
            `DMS_MODE_UNBUF: begin
                o_ladder_en = 1'b1;
                o_sw_three = 1'b1;
            end
            `DMS_MODE_UNBUF_AMP: begin
                o_ladder_en = 1'b1;
                o_amp_en = 1'b1;
                o_sw_one = 1'b1;
                o_sw_three = 1'b1;
            end
            `DMS_MODE_BUF: begin
                o_ladder_en = 1'b1;
                o_amp_en = 1'b1;
                o_sw_two = 1'b1;
            end
            default: begin
                o_valid = 1'b0;
            end
        endcase
        // Internal node follows the ladder enable in every mode
        o_int_node = o_ladder_en;
        if (i_stop) begin
            o_amp_en = 1'b0;
            o_sw_one = 1'b0;
            o_sw_two = 1'b0;
        end
    end

endmodule
`default_nettype wire

/* File: rtl/dms_top.v */
// APB register block and registered analog controls for the 8-bit DAC
// What this block does
// - Reset puts the mode field at Off so the converter starts idle.
// - Mode 000 disables ladder and amplifier and opens all switches.
// - Mode 001 enables only the amplifier and closes switch one.
// - Mode 010 enables only the ladder with every switch open.
// - Mode 100 enables the ladder and closes switch three only.
// - Mode 101 enables both parts and closes switches one and three.
// - Mode 111 enables both parts and closes switch two only.
// - Whenever the ladder is enabled it drives the internal node.
// - The range bit resets to full range.
// - Range zero gives 256 steps over 0.8 of span offset by 0.1.
// - Range one gives 256 steps over the full span from low reference.
// - A write of an unsupported mode leaves the mode field unchanged.
// - In stop the amplifier is off and switches one and two are open.
// - Stop does not disturb stored mode, range or level values.
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "dms_consts.vh"

module dms_top #(
    parameter ADDR_W = `DMS_ADDR_W     // APB address width
) (
    input wire I_CLK_SYS,              // 125 MHz bus clock
    input wire I_RESETN,               // Async reset, active low
    input wire I_PSEL,                 // APB select
    input wire I_PENABLE,              // APB access phase
    input wire I_PWRITE,               // APB direction, high for write
    input wire [ADDR_W-1:0] I_PADDR,   // APB byte address
    input wire [31:0] I_PWDATA,        // APB write data
    input wire [3:0] I_PSTRB,          // APB byte strobes
    input wire I_STOP,                 // System stop request
    output reg [31:0] O_PRDATA,        // APB read data
    output reg O_PREADY,               // APB ready
    output reg O_PSLVERR,              // APB error on unmapped address
    output reg O_LADDER_EN,            // Resistor network enable
    output reg O_AMP_EN,               // Amplifier enable
    output reg O_AMP_HIGH_DRIVE,       // Amplifier high drive select
    output reg O_SW_ONE,               // Switch one closed
    output reg O_SW_TWO,               // Switch two closed
    output reg O_SW_THREE,             // Switch three closed
    output reg O_INT_NODE_EN,          // Ladder drives internal node
    output reg O_FULL_RANGE,           // Full span when high
    output reg [7:0] O_LEVEL           // Level code to the ladder
);

    reg [2:0] mode_q;
    reg range_q;
    reg drive_q;
    reg [7:0] level_q;
    reg stop_q;
    wire setup_ok;
    wire [ADDR_W-1:0] word_addr;
    wire hit_ctrl;
    wire hit_level;
    wire hit_stop;
    wire hit_rsvd;
    wire mapped;
    wire wr_ok;
    wire dec_ladder;
    wire dec_amp;
    wire dec_one;
    wire dec_two;
    wire dec_three;
    wire dec_node;
    wire wr_mode_valid;
    wire stop_now;

    // Access phase answered one edge later: one wait state
    assign setup_ok = I_PSEL && I_PENABLE;
    assign word_addr = {I_PADDR[ADDR_W-1:2], 2'b00};
    assign hit_ctrl = (word_addr == `DMS_ADDR_CTRL);
    assign hit_level = (word_addr == `DMS_ADDR_LEVEL);
    assign hit_stop = (word_addr == `DMS_ADDR_STOP);
    assign hit_rsvd = (word_addr == `DMS_ADDR_RSVD1) ||
        (word_addr >= 12'h010 && word_addr <= `DMS_ADDR_RSVD7);
    assign mapped = hit_ctrl || hit_level || hit_stop || hit_rsvd;
    assign wr_ok = setup_ok && !O_PREADY && I_PWRITE && mapped;
    assign stop_now = I_STOP || stop_q;

    // Checks whether the written mode bits name a supported mode
    dms_decode u_wr_check (
        .i_mode(I_PWDATA[`DMS_FLD_MODE_HI:`DMS_FLD_MODE_LO]),
        .i_stop(1'b0),
        .o_ladder_en(),
        .o_amp_en(),
        .o_sw_one(),
        .o_sw_two(),
        .o_sw_three(),
        .o_int_node(),
        .o_valid(wr_mode_valid)
    );

    // Decodes the stored mode into the next control levels
    dms_decode u_decode (
        .i_mode(mode_q),
        .i_stop(stop_now),
        .o_ladder_en(dec_ladder),
        .o_amp_en(dec_amp),
        .o_sw_one(dec_one),
        .o_sw_two(dec_two),
        .o_sw_three(dec_three),
        .o_int_node(dec_node),
        .o_valid()
    );

    // Register writes; stop only masks outputs, never the stored fields
    always @(posedge I_CLK_SYS or negedge I_RESETN) begin
        if (!I_RESETN) begin
            mode_q <= `DMS_RST_MODE;
            range_q <= `DMS_RST_RANGE;
            drive_q <= `DMS_RST_DRIVE;
            level_q <= `DMS_RST_LEVEL;
            stop_q <= 1'b0;
        end else if (wr_ok && I_PSTRB[0]) begin
            if (hit_ctrl) begin
                if (wr_mode_valid) begin
                    mode_q <= I_PWDATA[`DMS_FLD_MODE_HI:`DMS_FLD_MODE_LO];
                end
                range_q <= I_PWDATA[`DMS_FLD_RANGE];
                drive_q <= I_PWDATA[`DMS_FLD_DRIVE];
            end
            if (hit_level) begin
                level_q <= I_PWDATA[7:0];
            end
            if (hit_stop) begin
                stop_q <= I_PWDATA[0];
            end
        end
    end

    // APB answer: ready after one wait state, error on unmapped words
    always @(posedge I_CLK_SYS or negedge I_RESETN) begin
        if (!I_RESETN) begin
            O_PREADY <= 1'b0;
            O_PSLVERR <= 1'b0;
            O_PRDATA <= 32'h00000000;
        end else if (setup_ok && !O_PREADY) begin
            O_PREADY <= 1'b1;
            O_PSLVERR <= !mapped;
            O_PRDATA <= 32'h00000000;
            if (!I_PWRITE && hit_ctrl) begin
                O_PRDATA <= {24'h000000, range_q, drive_q, 3'b000, mode_q};
            end
            if (!I_PWRITE && hit_level) begin
                O_PRDATA <= {24'h000000, level_q};
            end
            if (!I_PWRITE && hit_stop) begin
                O_PRDATA <= {30'h00000000, I_STOP, stop_q};
            end
        end else begin
            O_PREADY <= 1'b0;
            O_PSLVERR <= 1'b0;
            O_PRDATA <= 32'h00000000;
        end
    end

    // Registered analog controls, one edge behind the stored fields
    always @(posedge I_CLK_SYS or negedge I_RESETN) begin
        if (!I_RESETN) begin
            O_LADDER_EN <= 1'b0;
            O_AMP_EN <= 1'b0;
            O_AMP_HIGH_DRIVE <= `DMS_RST_DRIVE;
            O_SW_ONE <= 1'b0;
            O_SW_TWO <= 1'b0;
            O_SW_THREE <= 1'b0;
            O_INT_NODE_EN <= 1'b0;
            O_FULL_RANGE <= `DMS_RST_RANGE;
            O_LEVEL <= `DMS_RST_LEVEL;
        end else begin
            O_LADDER_EN <= dec_ladder;
            O_AMP_EN <= dec_amp;
            O_AMP_HIGH_DRIVE <= drive_q;
            O_SW_ONE <= dec_one;
            O_SW_TWO <= dec_two;
            O_SW_THREE <= dec_three;
            O_INT_NODE_EN <= dec_node;
            // Ladder scales by range: zero reduced span, one full span
            O_FULL_RANGE <= range_q;
            O_LEVEL <= level_q;
        end
    end

endmodule
`default_nettype wire

/* File: verif/dms_monitor.sv */
// Checker for decoded analog controls and APB answer timing
`timescale 1ns/10ps
`default_nettype none
module dms_monitor (
    input wire logic I_CLK_SYS, // Bus clock
    input wire logic I_RESETN, // Async reset, active low
    input wire logic I_PSEL, // APB select
    input wire logic I_PENABLE, // APB access
    input wire logic I_STOP, // System stop
    input wire logic O_PREADY, // APB ready
    input wire logic O_PSLVERR, // APB error
    input wire logic O_LADDER_EN, // Ladder enable
    input wire logic O_AMP_EN, // Amplifier enable
    input wire logic O_SW_ONE, // Switch one
    input wire logic O_SW_TWO, // Switch two
    input wire logic O_SW_THREE, // Switch three
    input wire logic O_INT_NODE_EN // Internal node drive
);
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_RESETN);
    // Switch patterns must match one supported mode at every cycle
    a_node_follow: assert property (O_INT_NODE_EN == O_LADDER_EN)
        else $error("internal node differs from ladder enable");
    a_off_open: assert property (!O_LADDER_EN && !O_AMP_EN |->
        !(O_SW_ONE || O_SW_TWO || O_SW_THREE)) else $error("switch on in off");
    a_one_amp: assert property (O_SW_ONE |-> O_AMP_EN)
        else $error("switch one closed with amplifier off");
    a_two_buf: assert property (O_SW_TWO |-> O_AMP_EN && O_LADDER_EN
        && !O_SW_ONE && !O_SW_THREE) else $error("bad buffered pattern");
    a_three_lad: assert property (O_SW_THREE |-> O_LADDER_EN)
        else $error("switch three closed with ladder off");
    a_amp_only: assert property (O_AMP_EN && !O_LADDER_EN |->
        O_SW_ONE && !O_SW_THREE) else $error("bad amplifier pattern");
    a_ladder_only: assert property (O_LADDER_EN && !O_AMP_EN |->
        !O_SW_ONE && !O_SW_TWO) else $error("bad ladder pattern");
    // Stop acts one edge later whatever the stored mode
    a_stop_amp: assert property (I_STOP |=> !O_AMP_EN &&
        !O_SW_ONE && !O_SW_TWO) else $error("amplifier path alive in stop");
    a_ready_lat: assert property (I_PSEL && I_PENABLE && !O_PREADY |=>
        O_PREADY) else $error("ready late");
    a_ready_one: assert property (O_PREADY |=> !O_PREADY)
        else $error("ready longer than one cycle");
    a_err_ready: assert property (O_PSLVERR |-> O_PREADY)
        else $error("error flag without ready");
    c_buffered: cover property (O_SW_TWO);
    c_both: cover property (O_SW_ONE && O_SW_THREE);
    c_stop: cover property (I_STOP && O_LADDER_EN);
endmodule
`default_nettype wire

/* File: verif/dms_analog.sv */
// Behavioural ladder, amplifier and switch network on the far side
`timescale 1ns/10ps
`default_nettype none
module dms_analog #(
    parameter int REF_MV = 5000 // High minus low reference, mV
) (
    input wire logic i_ladder_en, // Ladder on
    input wire logic i_amp_en, // Amplifier on
    input wire logic i_sw_two, // Buffer switch
    input wire logic i_sw_three, // Unbuffered switch
    input wire logic i_full, // Full span
    input wire logic [7:0] i_level, // Level code
    output logic [15:0] o_node_mv, // Internal node, mV
    output logic [15:0] o_unbuf_mv, // Unbuffered pin, mV
    output logic [15:0] o_amp_mv // Amplifier pin, mV
);
    logic [15:0] v;
    // Ladder step: full span, or 0.8 of span lifted by 0.1
    assign v = i_full ? 16'(i_level * REF_MV / 256)
        : 16'(i_level * (REF_MV * 4 / 5) / 256 + REF_MV / 10);
    // A released node shows all ones, never a stale level
    assign o_node_mv = i_ladder_en ? v : 16'hFFFF;
    assign o_unbuf_mv = (i_ladder_en && i_sw_three) ? v : 16'hFFFF;
    assign o_amp_mv = (i_amp_en && i_sw_two) ? v : 16'hFFFF;
endmodule
`default_nettype wire

/* File: verif/tb_dms_top.sv */
// Self-checking bench for the converter mode decoder
`timescale 1ns/10ps
`default_nettype none
`include "dms_consts.vh"
module tb_dms_top;
    logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic stop = 1'b0;
    logic [3:0] strb = 4'hF;
    logic [11:0] addr = 12'h000;
    logic [31:0] wdat = 32'h0, prdata;
    logic prdy, perr, lad, amplifier_out_pin, drv, s1, s2, s3, node, full;
    logic [7:0] lvl, lw;
    logic [15:0] nmv, umv, amv;
    logic [1:0] rd;
    logic [2:0] cur;
    logic [33:0] exq[$];
    logic [33:0] e;
    int n_errors = 0, n_checks = 0, seed = 32'h2072;
    // Half period of 4 ns gives 125 MHz
    always #4 clk = ~clk;
    dms_top u_dms_top (.I_CLK_SYS(clk), .I_RESETN(rst_n), .I_PSEL(psel),
        .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(addr), .I_PWDATA(wdat),
        .I_PSTRB(strb), .I_STOP(stop), .O_PRDATA(prdata), .O_PREADY(prdy),
        .O_PSLVERR(perr), .O_LADDER_EN(lad), .O_AMP_EN(amplifier_out_pin),
        .O_AMP_HIGH_DRIVE(drv), .O_SW_ONE(s1), .O_SW_TWO(s2),
        .O_SW_THREE(s3), .O_INT_NODE_EN(node), .O_FULL_RANGE(full),
        .O_LEVEL(lvl));
    dms_analog u_dms_analog (.i_ladder_en(lad), .i_amp_en(amplifier_out_pin),
        .i_sw_two(s2), .i_sw_three(s3), .i_full(full), .i_level(lvl),
        .o_node_mv(nmv), .o_unbuf_mv(umv), .o_amp_mv(amv));
    task automatic summarize;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One APB transfer; read data is only compared when no error is due
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d, input logic err);
        int k;
        exq.push_back({!w && !err, err, d});
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        addr <= a;
        wdat <= d;
        @(posedge clk);
        pen <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge clk);
            if (prdy === 1'b1)
                break;
        end
        if (k == 20) begin
            n_errors++;
            summarize();
        end
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    // Expected {ladder, amplifier, switch one, two, three}
    function automatic logic [4:0] dx(input logic [2:0] m);
        case (m)
            3'h1: dx = 5'h0C;
            3'h2: dx = 5'h10;
            3'h4: dx = 5'h11;
            3'h5: dx = 5'h1D;
            3'h7: dx = 5'h1A;
            default: dx = 5'h00;
        endcase
    endfunction
    // Controls lag the stored field by one edge, so wait two
    task automatic dec(input logic [4:0] x);
        repeat (2) @(posedge clk);
        chk({27'h0, lad, amplifier_out_pin, s1, s2, s3}, {27'h0, x});
        chk({31'h0, node}, {31'h0, x[4]});
    endtask
    // Answers are matched to the oldest note at the ready edge
    always @(posedge clk) begin
        if (prdy === 1'b1 && psel && pen) begin
            e = exq.pop_front();
            chk({31'h0, perr}, {31'h0, e[32]});
            if (e[33])
                chk(prdata, e[31:0]);
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        apb(0, `DMS_ADDR_CTRL, 32'h80, 0);
        chk({31'h0, full}, 32'h1);
        dec(5'h00);
        cur = 3'h0;
        for (int m = 0; m < 8; m++) begin
            rd = $random(seed);
            apb(1, `DMS_ADDR_CTRL, {24'h0, rd, 3'h0, m[2:0]}, 0);
            if (m != 3 && m != 6)
                cur = m[2:0];
            dec(dx(cur));
            chk({30'h0, full, drv}, {30'h0, rd});
            apb(0, `DMS_ADDR_CTRL, {24'h0, rd, 3'h0, cur}, 0);
        end
        $display("mode table done");
        lw = $random(seed);
        apb(1, `DMS_ADDR_LEVEL, {24'h0, lw}, 0);
        apb(0, `DMS_ADDR_LEVEL, {24'h0, lw}, 0);
        chk({24'h0, lvl}, {24'h0, lw});
        // A write without the low byte strobe must leave the level alone
        strb <= 4'hE;
        apb(1, `DMS_ADDR_LEVEL, 32'h5A, 0);
        strb <= 4'hF;
        apb(0, `DMS_ADDR_LEVEL, {24'h0, lw}, 0);
        chk({24'h0, lvl}, {24'h0, lw});
        apb(0, 12'h040, 32'h0, 1);
        // Reserved words answer without error and read zero
        apb(0, `DMS_ADDR_RSVD1, 32'h0, 0);
        apb(0, `DMS_ADDR_RSVD7, 32'h0, 0);
        apb(1, `DMS_ADDR_LEVEL, 32'hFF, 0);
        for (int f = 0; f < 2; f++) begin
            apb(1, `DMS_ADDR_CTRL, {24'h0, f[0], 7'h07}, 0);
            dec(5'h1A);
            chk({16'h0, amv}, f ? 32'd4980 : 32'd4484);
            chk({16'h0, nmv}, f ? 32'd4980 : 32'd4484);
        end
        $display("range test done");
        apb(1, `DMS_ADDR_CTRL, 32'h85, 0);
        stop <= 1'b1;
        dec(5'h11);
        chk({16'h0, umv}, 32'd4980);
        apb(0, `DMS_ADDR_CTRL, 32'h85, 0);
        apb(0, `DMS_ADDR_STOP, 32'h2, 0);
        stop <= 1'b0;
        dec(5'h1D);
        apb(1, `DMS_ADDR_STOP, 32'h1, 0);
        dec(5'h11);
        apb(1, `DMS_ADDR_STOP, 32'h0, 0);
        dec(5'h1D);
        $display("stop test done");
        summarize();
    end
endmodule
bind dms_top dms_monitor u_dms_monitor (.I_CLK_SYS(I_CLK_SYS),
    .I_RESETN(I_RESETN), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
    .I_STOP(I_STOP), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
    .O_LADDER_EN(O_LADDER_EN),
    .O_AMP_EN(O_AMP_EN), .O_SW_ONE(O_SW_ONE), .O_SW_TWO(O_SW_TWO),
    .O_SW_THREE(O_SW_THREE), .O_INT_NODE_EN(O_INT_NODE_EN));
`default_nettype wire
